//--- logic/thru_top.sv
`timescale 1ns/10ps
module thru_top (
	// Clock and power-up reset
	input  wire logic        CLK_IN,
	input  wire logic        RST_IN,
	// APB slave
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	// Timer sources, one-cycle ticks
	input  wire logic        WDT_OSC_TICK_IN,
	input  wire logic        RTC_OSC_TICK_IN,
	// Core events
	input  wire logic        HALT_OP_IN,
	input  wire logic        WDT_CLEAR_OP_IN,
	input  wire logic        WDT_OVF_IN,
	input  wire logic        EXT_CLEAR_N_IN,
	input  wire logic [7:0]  PORTA_IN,
	input  wire logic [3:0]  EXT_IRQ_REQ_IN,
	input  wire logic        MASTER_IRQ_EN_IN,
	input  wire logic        STACK_FULL_IN,
	input  wire logic        IRQ_ACK_IN,
	// Core control
	output logic             CPU_RUN_OUT,
	output logic             SYS_OSC_EN_OUT,
	output logic             IO_HOLD_OUT,
	output logic             CHIP_RESET_OUT,
	output logic             WARM_RESET_OUT,
	output logic             WDT_CLEAR_OUT,
	output logic             RESUME_NEXT_OUT,
	output logic             IRQ_VEC_REQ_OUT,
	output logic      [7:0]  IRQ_VEC_OUT,
	// Tap clocks
	output logic             LCD_CLK_OUT,
	output logic             BUZZER_OUT
);
	thru_core_if core ();

	thru_pkg::thru_state_type state_q, state_d;
	logic [7:0]  tick_ctl_q;
	logic [7:0]  irq_ctl2_q;
	logic [23:0] options_q;
	logic        pdf_q, to_q;
	logic [5:0]  pre_req_q;
	logic [7:0]  porta_q;
	logic [1:0]  idiv_q;
	logic        resume_pend_q, settle_q;
	logic        vec_req_q, sys_osc_q, run_q, hold_q;
	logic        chip_rst_q, warm_q, wdt_clr_q, resume_q;
	logic [7:0]  vec_q;
	logic [31:0] rdata_q;
	logic        pready_q, pslverr_q;
	logic [10:0] wake_cnt_q;

	// Decoded events
	wire         setup_ph    = PSEL_IN && !PENABLE_IN;
	wire         wr_done     = PSEL_IN && PENABLE_IN && pready_q && PWRITE_IN;
	wire  [7:0]  idx         = {2'b00, PADDR_IN[7:2]};
	wire         hit_tick    = idx == thru_pkg::IDX_TICK_CTL;
	wire         hit_stat    = idx == thru_pkg::IDX_STATUS;
	wire         hit_irq     = idx == thru_pkg::IDX_IRQ_CTL2;
	wire         hit_opt     = idx == thru_pkg::IDX_OPTIONS;
	wire         mapped      = (hit_tick || hit_stat || hit_irq || hit_opt) && PADDR_IN[1:0] == 2'b00;
	wire  [1:0]  src_sel     = options_q[thru_pkg::OPT_SRC_LSB +: 2];
	wire  [7:0]  wake_en     = options_q[thru_pkg::OPT_WAKE_LSB +: 8];
	wire         slow_src    = src_sel == thru_pkg::SRC_WDT || src_sel == thru_pkg::SRC_RTC;
	wire         in_run      = state_q == thru_pkg::ST_RUN;
	wire         in_halt     = state_q == thru_pkg::ST_HALT;
	wire         halt_go     = in_run && HALT_OP_IN && EXT_CLEAR_N_IN;
	wire         ext_clear   = !EXT_CLEAR_N_IN;
	wire         ovf_run     = in_run && WDT_OVF_IN;
	wire         ovf_halt    = in_halt && WDT_OVF_IN;
	wire         chip_rst    = ext_clear || ovf_run;
	wire         periodic_tick_flag         = irq_ctl2_q[thru_pkg::TBF_BIT];
	wire         clock_tick_flag         = irq_ctl2_q[thru_pkg::RTF_BIT];
	wire  [5:0]  req_all     = {clock_tick_flag, periodic_tick_flag, EXT_IRQ_REQ_IN};
	wire  [5:0]  new_req     = req_all & ~pre_req_q;
	wire         port_wake   = |(porta_q & ~PORTA_IN & wake_en);
	wire         any_wake    = |new_req || port_wake;
	wire         instr_tick  = sys_osc_q && idiv_q == thru_pkg::INSTR_DIV_LAST;
	wire         tb_pend     = periodic_tick_flag && irq_ctl2_q[thru_pkg::TB_EN_BIT];
	wire         rtc_pend    = clock_tick_flag && irq_ctl2_q[thru_pkg::RTC_EN_BIT];
	wire         vec_ok      = run_q && !settle_q && MASTER_IRQ_EN_IN && !STACK_FULL_IN;
	wire         ack_tb      = IRQ_ACK_IN && vec_req_q && vec_q == thru_pkg::VEC_TB;
	wire         ack_rtc     = IRQ_ACK_IN && vec_req_q && vec_q == thru_pkg::VEC_RTC;
	wire         wr_irq      = wr_done && hit_irq;

	// Shared timer wiring; instruction tick stops with the system oscillator [RULE_01] [RULE_22]
	assign core.src_tick  = (src_sel == thru_pkg::SRC_WDT)   ? WDT_OSC_TICK_IN :
	                        (src_sel == thru_pkg::SRC_RTC)   ? RTC_OSC_TICK_IN :
	                        (src_sel == thru_pkg::SRC_INSTR) ? instr_tick : 1'b0;
	assign core.tmr_clear = chip_rst; // [RULE_20]
	assign core.lcd_sel   = options_q[thru_pkg::OPT_LCD_LSB +: 3] > 3'h6 ? 3'h6 :
	                        options_q[thru_pkg::OPT_LCD_LSB +: 3];
	assign core.buz_sel   = options_q[thru_pkg::OPT_BUZ_LSB +: 3];
	assign core.tb_sel    = options_q[thru_pkg::OPT_TB_LSB +: 2];
	assign core.rtc_sel   = tick_ctl_q[2:0]; // [RULE_06]
	assign core.sst_start = state_q != thru_pkg::ST_WAKE && state_d == thru_pkg::ST_WAKE;

	thru_mft u_mft (
		.clk_in (CLK_IN),
		.rst_in (RST_IN),
		.core   (core)
	);

	thru_sst u_sst (
		.clk_in (CLK_IN),
		.rst_in (RST_IN),
		.core   (core)
	);

	// Sequencer: overflow in halt is a warm reset and still waits out the delay [RULE_13]
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			thru_pkg::ST_RUN: begin
				if (halt_go) state_d = thru_pkg::ST_HALT;
			end
			thru_pkg::ST_HALT: begin
				if (ext_clear || WDT_OVF_IN || any_wake) state_d = thru_pkg::ST_WAKE;
			end
			thru_pkg::ST_WAKE: begin
				if (core.sst_done) state_d = thru_pkg::ST_RUN; // [RULE_18]
			end
		endcase
	end

	// State, instruction divider and port A history
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			state_q <= thru_pkg::ST_WAKE;
			idiv_q  <= 2'h0;
			porta_q <= 8'hFF;
		end else begin
			state_q <= state_d;
			idiv_q  <= sys_osc_q ? idiv_q + 2'h1 : 2'h0;
			porta_q <= PORTA_IN;
		end
	end

	// Cause flags; clear op loses to a halt in the same cycle [RULE_19]
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pdf_q <= 1'b0; // [RULE_14]
			to_q  <= 1'b0;
		end else if (halt_go) begin
			pdf_q <= 1'b1; // [RULE_11]
			to_q  <= 1'b0;
		end else if (in_halt && ext_clear) begin
			to_q  <= 1'b0;
		end else if (WDT_OVF_IN && (in_run || in_halt)) begin
			to_q  <= 1'b1; // [RULE_21]
		end else if (WDT_CLEAR_OP_IN && in_run) begin
			pdf_q <= 1'b0; // [RULE_14]
		end
	end

	// Requests already pending at halt entry are masked out of wake [RULE_17]
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			pre_req_q <= 6'h00;
		end else if (halt_go) begin
			pre_req_q <= req_all;
		end
	end

	// Tick control register; chip reset returns the rate to its reset code
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || chip_rst) begin
			tick_ctl_q <= thru_pkg::TICK_CTL_RESET; // [RULE_20]
		end else if (wr_done && hit_tick) begin
			tick_ctl_q <= PWDATA_IN[7:0]; // [RULE_06]
		end
	end

	// Options are not cleared by a chip reset, as mask options would not be
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			options_q <= 24'h000000;
		end else if (wr_done && hit_opt) begin
			options_q <= PWDATA_IN[23:0]; // [RULE_15]
		end
	end

	// Second interrupt control; hardware set beats software or ack clear [RULE_05] [RULE_07]
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || chip_rst) begin
			irq_ctl2_q <= 8'h00; // [RULE_20]
		end else begin
			irq_ctl2_q[thru_pkg::TB_EN_BIT] <= wr_irq ? PWDATA_IN[thru_pkg::TB_EN_BIT] :
			                                   irq_ctl2_q[thru_pkg::TB_EN_BIT];
			irq_ctl2_q[thru_pkg::RTC_EN_BIT] <= wr_irq ? PWDATA_IN[thru_pkg::RTC_EN_BIT] :
			                                    irq_ctl2_q[thru_pkg::RTC_EN_BIT];
			irq_ctl2_q[thru_pkg::TBF_BIT] <= core.tb_tick ||
				(!ack_tb && (wr_irq ? PWDATA_IN[thru_pkg::TBF_BIT] : periodic_tick_flag)); // [RULE_05]
			irq_ctl2_q[thru_pkg::RTF_BIT] <= core.rtc_tick ||
				(!ack_rtc && (wr_irq ? PWDATA_IN[thru_pkg::RTF_BIT] : clock_tick_flag)); // [RULE_07]
		end
	end

	// Vector request; one settle cycle after wake delays the response [RULE_16]
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || chip_rst) begin
			vec_req_q <= 1'b0;
			vec_q     <= 8'h00;
		end else if (!vec_req_q || IRQ_ACK_IN) begin
			vec_req_q <= vec_ok && (tb_pend || rtc_pend) && !IRQ_ACK_IN;
			vec_q     <= tb_pend ? thru_pkg::VEC_TB : thru_pkg::VEC_RTC; // [RULE_05] [RULE_07]
		end
	end

	// Core control outputs; halt freezes execution and ports [RULE_08] [RULE_09]
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			sys_osc_q     <= 1'b1;
			run_q         <= 1'b0;
			hold_q        <= 1'b0;
			settle_q      <= 1'b0;
			chip_rst_q    <= 1'b1; // [RULE_20]
			warm_q        <= 1'b0;
			wdt_clr_q     <= 1'b0;
			resume_q      <= 1'b0;
			resume_pend_q <= 1'b0;
		end else begin
			sys_osc_q     <= state_d != thru_pkg::ST_HALT; // [RULE_08]
			run_q         <= state_d == thru_pkg::ST_RUN;
			hold_q        <= state_d == thru_pkg::ST_HALT; // [RULE_09]
			settle_q      <= state_q == thru_pkg::ST_WAKE && state_d == thru_pkg::ST_RUN;
			chip_rst_q    <= chip_rst; // [RULE_13] [RULE_21]
			warm_q        <= ovf_halt; // [RULE_13]
			wdt_clr_q     <= halt_go && slow_src; // [RULE_10]
			resume_q      <= resume_pend_q && state_q == thru_pkg::ST_WAKE && core.sst_done;
			if (in_halt && state_d == thru_pkg::ST_WAKE) begin
				resume_pend_q <= !(ext_clear || WDT_OVF_IN); // [RULE_15] [RULE_16]
			end else if (core.sst_done) begin
				resume_pend_q <= 1'b0;
			end
		end
	end

	// APB read data and ready; one wait-free access phase
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			rdata_q   <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup_ph;
			pslverr_q <= setup_ph && !mapped;
			if (setup_ph) begin
				rdata_q <= !mapped ? 32'h00000000 :
				           hit_tick ? {24'h000000, tick_ctl_q} :
				           hit_irq  ? {24'h000000, irq_ctl2_q} :
				           hit_opt  ? {8'h00, options_q} :
				           {26'h0000000, to_q, pdf_q, 4'h0}; // [RULE_19]
			end
		end
	end

	// Wake length counter, read only by checks
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || core.sst_start) begin
			wake_cnt_q <= 11'h000;
		end else if (state_q == thru_pkg::ST_WAKE) begin
			wake_cnt_q <= wake_cnt_q + 11'h001;
		end
	end

	assign PRDATA_OUT      = rdata_q;
	assign PREADY_OUT      = pready_q;
	assign PSLVERR_OUT     = pslverr_q;
	assign CPU_RUN_OUT     = run_q;
	assign SYS_OSC_EN_OUT  = sys_osc_q;
	assign IO_HOLD_OUT     = hold_q;
	assign CHIP_RESET_OUT  = chip_rst_q;
	assign WARM_RESET_OUT  = warm_q;
	assign WDT_CLEAR_OUT   = wdt_clr_q;
	assign RESUME_NEXT_OUT = resume_q;
	assign IRQ_VEC_REQ_OUT = vec_req_q;
	assign IRQ_VEC_OUT     = vec_q;
	assign LCD_CLK_OUT     = core.lcd_clk;
	assign BUZZER_OUT      = core.buz_clk;

	// Checks
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	sequence halt_entry_s;
		halt_go;
	endsequence
	sequence halt_held_s;
		!SYS_OSC_EN_OUT && IO_HOLD_OUT && !CPU_RUN_OUT;
	endsequence

	halt_flags_a: assert property (halt_entry_s |=> pdf_q && !to_q) // [RULE_11]
		else $error("halt entry did not set pdf and clear to");
	osc_stop_a: assert property (halt_entry_s |=> halt_held_s) // [RULE_08]
		else $error("halt did not stop oscillator and hold ports");
	wdt_clear_a: assert property (halt_entry_s ##0 slow_src |=> WDT_CLEAR_OUT) // [RULE_10]
		else $error("watchdog not cleared on halt entry");
	tb_flag_a: assert property (core.tb_tick |=> periodic_tick_flag) // [RULE_05]
		else $error("time base tick lost");
	rtc_flag_a: assert property (core.rtc_tick |=> clock_tick_flag) // [RULE_07]
		else $error("clock tick lost");
	warm_reset_a: assert property (ovf_halt |=> WARM_RESET_OUT && to_q && pdf_q) // [RULE_13]
		else $error("warm reset wrong");
	pdf_clear_a: assert property (WDT_CLEAR_OP_IN && in_run && !halt_go && !WDT_OVF_IN
		|=> !pdf_q) // [RULE_14]
		else $error("pdf not cleared by watchdog clear");
	stale_irq_a: assert property (in_halt && !any_wake && !WDT_OVF_IN && !ext_clear
		|=> state_q == thru_pkg::ST_HALT) // [RULE_17]
		else $error("stale request woke device");
	sst_len_a: assert property (state_q == thru_pkg::ST_WAKE && state_d == thru_pkg::ST_RUN
		|-> wake_cnt_q == thru_pkg::SST_CYCLES - 11'h001) // [RULE_18]
		else $error("startup delay length wrong");
	vec_gate_a: assert property ($rose(IRQ_VEC_REQ_OUT) |-> $past(vec_ok)) // [RULE_16]
		else $error("vector requested while masked");
	ovf_run_a: assert property (ovf_run |=> CHIP_RESET_OUT && to_q) // [RULE_21]
		else $error("overflow in run missed reset");
endmodule : thru_top

//--- logic/thru_pkg.sv
// Function
// RULE_01: Shared timer: 8-stage divider plus 7-bit prescaler.
// RULE_02: Option-selected LCD and buzzer clock taps.
// RULE_03: Integrator picks LCD tap near 4kHz.
// RULE_04: Time base period 2^12 to 2^15.
// RULE_05: Time base sets tick flag, vector 14H.
// RULE_06: Rate select bits choose clock tick divide.
// RULE_07: Clock tick sets flag, vector 18H.
// RULE_08: Halt stops system oscillator, slow oscillator runs.
// RULE_09: Halt keeps RAM, registers and ports.
// RULE_10: Halt entry clears watchdog on slow source.
// RULE_11: Halt sets power-down flag, clears expiry flag.
// RULE_12: LCD clock runs in halt on slow source.
// RULE_13: Halt ends by reset, interrupt, port, overflow.
// RULE_14: Power-down flag cleared by power-up, watchdog clear.
// RULE_15: Port A wake enables; resume next instruction.
// RULE_16: Disabled or stack-full interrupt wake resumes next.
// RULE_17: Already-set request flag cannot wake device.
// RULE_18: Startup delay 1024 clocks after power-up, wake.
// RULE_19: Expiry and power-down flags encode reset cause.
// RULE_20: Chip reset clears timers, disables interrupts.
// RULE_21: Overflow in run: chip reset, expiry flag set.
// RULE_22: Shared timer counts in halt on slow source.
package thru_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [7:0]  IDX_TICK_CTL   = 8'h09;
	localparam logic [7:0]  IDX_STATUS     = 8'h0A;
	localparam logic [7:0]  IDX_IRQ_CTL2   = 8'h1E;
	localparam logic [7:0]  IDX_OPTIONS    = 8'h20;
	localparam logic [7:0]  TICK_CTL_RESET = 8'h07;
	// Field positions
	localparam int          TB_EN_BIT      = 2;
	localparam int          RTC_EN_BIT     = 3;
	localparam int          PDF_BIT        = 4;
	localparam int          TO_BIT         = 5;
	localparam int          TBF_BIT        = 5;
	localparam int          RTF_BIT        = 6;
	localparam int          OPT_SRC_LSB    = 0;
	localparam int          OPT_LCD_LSB    = 2;
	localparam int          OPT_BUZ_LSB    = 5;
	localparam int          OPT_TB_LSB     = 8;
	localparam int          OPT_WAKE_LSB   = 16;
	// Tap bases: tap exponent is base plus select code
	localparam logic [3:0]  LCD_BASE       = 4'h2;
	localparam logic [3:0]  BUZ_BASE       = 4'h2;
	localparam logic [3:0]  TB_BASE        = 4'hC;
	localparam logic [3:0]  RTC_BASE       = 4'h8;
	localparam int          TMR_BITS       = 15;
	// Vectors
	localparam logic [7:0]  VEC_TB         = 8'h14;
	localparam logic [7:0]  VEC_RTC        = 8'h18;
	// Startup delay in system clock periods
	localparam logic [10:0] SST_CYCLES     = 11'h400;
	localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;

	typedef enum logic [1:0] {SRC_WDT, SRC_RTC, SRC_INSTR, SRC_NONE} thru_src_type;
	typedef enum {ST_RUN, ST_HALT, ST_WAKE} thru_state_type;

	// Divide-by-2^n rollover: low n bits all ones
	function automatic logic thru_roll(input logic [14:0] cnt, input logic [3:0] n);
		logic [15:0] mask;
		mask = (16'h0001 << n) - 16'h0001;
		return ({1'b0, cnt} & mask) == mask;
	endfunction : thru_roll
endpackage : thru_pkg

//--- logic/thru_core_if.sv
`timescale 1ns/10ps
interface thru_core_if;
	logic       src_tick;
	logic       tmr_clear;
	logic [2:0] lcd_sel;
	logic [2:0] buz_sel;
	logic [1:0] tb_sel;
	logic [2:0] rtc_sel;
	logic       tb_tick;
	logic       rtc_tick;
	logic       lcd_clk;
	logic       buz_clk;
	logic       sst_start;
	logic       sst_busy;
	logic       sst_done;

	modport tmr (input src_tick, tmr_clear, lcd_sel, buz_sel, tb_sel, rtc_sel,
		output tb_tick, rtc_tick, lcd_clk, buz_clk);
	modport sst (input sst_start, output sst_busy, sst_done);
	modport ctl (output src_tick, tmr_clear, lcd_sel, buz_sel, tb_sel, rtc_sel, sst_start,
		input tb_tick, rtc_tick, lcd_clk, buz_clk, sst_busy, sst_done);
endinterface : thru_core_if

//--- logic/thru_mft.sv
`timescale 1ns/10ps
module thru_mft (
	input wire logic clk_in,
	input wire logic rst_in,
	thru_core_if.tmr core
);
	logic [14:0] cnt_q;
	logic [3:0]  lcd_n, buz_n, tb_n, rtc_n;

	// Tap exponents from option and rate select codes
	assign lcd_n = thru_pkg::LCD_BASE + {1'b0, core.lcd_sel};
	assign buz_n = thru_pkg::BUZ_BASE + {1'b0, core.buz_sel};
	assign tb_n  = thru_pkg::TB_BASE + {2'b00, core.tb_sel};
	assign rtc_n = thru_pkg::RTC_BASE + {1'b0, core.rtc_sel};

	// Divider and prescaler as one 15-bit chain; only the source tick advances it [RULE_01] [RULE_22]
	always_ff @(posedge clk_in) begin
		if (rst_in || core.tmr_clear) begin
			cnt_q <= 15'h0000;
		end else if (core.src_tick) begin
			cnt_q <= cnt_q + 15'h0001;
		end
	end

	// Time-outs and square-wave taps, all registered
	always_ff @(posedge clk_in) begin
		if (rst_in || core.tmr_clear) begin
			core.tb_tick  <= 1'b0;
			core.rtc_tick <= 1'b0;
			core.lcd_clk  <= 1'b0;
			core.buz_clk  <= 1'b0;
		end else begin
			core.tb_tick  <= core.src_tick && thru_pkg::thru_roll(cnt_q, tb_n); // [RULE_04]
			core.rtc_tick <= core.src_tick && thru_pkg::thru_roll(cnt_q, rtc_n); // [RULE_06]
			core.lcd_clk  <= cnt_q[lcd_n - 4'h1]; // [RULE_02] [RULE_12]
			core.buz_clk  <= cnt_q[buz_n - 4'h1]; // [RULE_02]
		end
	end
endmodule : thru_mft

//--- logic/thru_sst.sv
`timescale 1ns/10ps
module thru_sst (
	input wire logic clk_in,
	input wire logic rst_in,
	thru_core_if.sst core
);
	logic [10:0] cnt_q;

	// Startup delay; busy from power-up so the first run also waits [RULE_18]
	always_ff @(posedge clk_in) begin
		if (rst_in || core.sst_start) begin
			cnt_q         <= 11'h000;
			core.sst_busy <= 1'b1;
			core.sst_done <= 1'b0;
		end else if (core.sst_busy) begin
			cnt_q         <= cnt_q + 11'h001;
			core.sst_done <= (cnt_q == thru_pkg::SST_CYCLES - 11'h002);
			core.sst_busy <= (cnt_q != thru_pkg::SST_CYCLES - 11'h002);
		end else begin
			core.sst_done <= 1'b0;
		end
	end
endmodule : thru_sst

//--- sim/thru_pins_model.sv
`timescale 1ns/10ps
// Far side pins: port A and the external clear pin, both pulled high when idle
module thru_pins_model (
	// Clock for pin changes
	input  wire logic       clk_in,
	// Pin levels
	output logic      [7:0] porta_out,
	output logic            clear_n_out
);
	// Pull-up levels at time zero
	initial begin
		porta_out   = 8'hFF;
		clear_n_out = 1'b1;
	end

	// One falling edge on a port A pin, then back to the pull-up level
	task automatic fall(input int b);
		@(posedge clk_in);
		porta_out[b] <= 1'b0;
		repeat (4) @(posedge clk_in);
		porta_out[b] <= 1'b1;
	endtask : fall

	// Clear pin held low a few cycles; a glitch would not be a real reset
	task automatic pin_reset();
		@(posedge clk_in);
		clear_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		clear_n_out <= 1'b1;
	endtask : pin_reset
endmodule : thru_pins_model

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic        clk    = 1'b0;
	logic        rst    = 1'b1;
	logic        psel   = 1'b0;
	logic        pen    = 1'b0;
	logic        pwr    = 1'b0;
	logic [7:0]  paddr  = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        wdt_tk = 1'b1;
	logic        rtc_tk = 1'b0;
	logic        halt   = 1'b0;
	logic        wclr   = 1'b0;
	logic        ovf    = 1'b0;
	logic        ack    = 1'b0;
	logic        mien   = 1'b1;
	logic        sfull  = 1'b0;
	logic [3:0]  req    = 4'h0;
	logic [31:0] prdata, rd;
	logic [7:0]  porta, vec;
	logic        pready, pslverr, clr_n, run, osc_en, io_hold, chip_rst;
	logic        warm_rst, wdt_clr, res_next, vreq, lcd, buz, err, prv;
	int          fails = 0;
	int          total_checks = 0;
	int          n, k, off;
	localparam logic [7:0] A_TICK = thru_pkg::IDX_TICK_CTL << 2;
	localparam logic [7:0] A_STAT = thru_pkg::IDX_STATUS << 2;
	localparam logic [7:0] A_IRQ  = thru_pkg::IDX_IRQ_CTL2 << 2;
	localparam logic [7:0] A_OPT  = thru_pkg::IDX_OPTIONS << 2;

	// 40 MHz clock
	always #12.5 clk = ~clk;
	// Unselected slow source still toggles at random
	always @(posedge clk) rtc_tk <= 1'($urandom % 2);

	thru_top u_thru_top (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .WDT_OSC_TICK_IN(wdt_tk),
		.RTC_OSC_TICK_IN(rtc_tk), .HALT_OP_IN(halt), .WDT_CLEAR_OP_IN(wclr),
		.WDT_OVF_IN(ovf), .EXT_CLEAR_N_IN(clr_n), .PORTA_IN(porta), .EXT_IRQ_REQ_IN(req),
		.MASTER_IRQ_EN_IN(mien), .STACK_FULL_IN(sfull), .IRQ_ACK_IN(ack),
		.CPU_RUN_OUT(run), .SYS_OSC_EN_OUT(osc_en), .IO_HOLD_OUT(io_hold),
		.CHIP_RESET_OUT(chip_rst), .WARM_RESET_OUT(warm_rst), .WDT_CLEAR_OUT(wdt_clr),
		.RESUME_NEXT_OUT(res_next), .IRQ_VEC_REQ_OUT(vreq), .IRQ_VEC_OUT(vec),
		.LCD_CLK_OUT(lcd), .BUZZER_OUT(buz));
	thru_pins_model u_thru_pins_model (.clk_in(clk), .porta_out(porta), .clear_n_out(clr_n));

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk

	// APB transfer; ready, data and error taken at the edge that sees pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int c;
		c = 0;
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			c++;
		end while (pready !== 1'b1 && c < 20);
		rd  = prdata;
		err = pslverr;
		if (c >= 20) fails++;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb

	// One-cycle pulse on an event input
	task automatic pulse(input int which);
		@(posedge clk);
		case (which)
			0: halt <= 1'b1;
			1: wclr <= 1'b1;
			2: ovf <= 1'b1;
			default: ack <= 1'b1;
		endcase
		@(posedge clk);
		{halt, wclr, ovf, ack} <= 4'h0;
	endtask : pulse

	// Bounded wait for run (0) or a vector request (1)
	task automatic wait_on(input int which, input int lim);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (n < lim && (which == 0 ? run : vreq) !== 1'b1);
	endtask : wait_on

	// Halt entry and its immediate effects
	task automatic halt_in();
		pulse(0);
		@(negedge clk);
		chk(osc_en, 0);
		chk(io_hold, 1);
		chk(wdt_clr, 1);
		chk(run, 0);
	endtask : halt_in

	// Wake-up: startup delay, then resume flag as expected
	task automatic woke(input logic nxt);
		wait_on(0, 1200);
		chk(n >= 1024 && n <= 1030, 1);
		chk(res_next, nxt);
	endtask : woke

	task automatic stat(input logic [1:0] exp);
		apb(1'b0, A_STAT, 32'h0);
		chk(rd[5:4], exp);
	endtask : stat

	task automatic results();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	// Main sequence
	initial begin
		void'($urandom(32'h2826));
		@(posedge clk);
		@(negedge clk);
		chk(chip_rst, 1);
		@(posedge clk);
		rst <= 1'b0;
		woke(1'b0);
		apb(1'b0, A_TICK, 32'h0);
		chk(rd[7:0], thru_pkg::TICK_CTL_RESET);
		stat(2'b00);
		apb(1'b0, 8'hFC, 32'h0);
		chk(err, 1);
		$display("test reset done");
		off = $urandom % 8;
		for (int i = 0; i < 9; i++) begin
			k = (i == 8) ? 4 : (i + off) % 8;
			apb(1'b1, A_TICK, k);
			apb(1'b0, A_TICK, 32'h0);
			chk(rd[2:0], k);
		end
		k = $urandom % 8;
		apb(1'b1, A_OPT, 32'h1 << (16 + k));
		apb(1'b1, A_IRQ, 32'h0);
		repeat (4200) @(posedge clk);
		apb(1'b0, A_IRQ, 32'h0);
		chk(rd[6:5], 2'b11);
		$display("test rates done");
		// Pending request and disabled pin must not wake; new request must
		req[0] <= 1'b1;
		halt_in();
		n = 0;
		prv = lcd;
		repeat (40) begin
			@(negedge clk);
			if (lcd === 1'b1 && prv === 1'b0) n++;
			prv = lcd;
		end
		chk(n, 10);
		stat(2'b01);
		u_thru_pins_model.fall((k + 1) % 8);
		chk(osc_en, 0);
		req[1] <= 1'b1;
		woke(1'b1);
		pulse(1);
		apb(1'b0, A_STAT, 32'h0);
		chk(rd[4], 0);
		halt_in();
		// Enabled pin falls in halt; its fall starts the delay count
		fork
			u_thru_pins_model.fall(k);
		join_none
		woke(1'b1);
		$display("test wake done");
		halt_in();
		pulse(2);
		@(negedge clk);
		chk(warm_rst, 1);
		woke(1'b0);
		stat(2'b11);
		halt_in();
		fork
			u_thru_pins_model.pin_reset();
		join_none
		repeat (3) @(negedge clk);
		chk(chip_rst, 1);
		wait_on(0, 1300);
		// Counted from two edges after the pin was seen low
		chk(n >= 1023 && n <= 1024, 1);
		stat(2'b01);
		apb(1'b0, A_TICK, 32'h0);
		chk(rd[7:0], thru_pkg::TICK_CTL_RESET);
		pulse(2);
		@(negedge clk);
		chk(chip_rst, 1);
		// Overflow in run is no wake-up, so no startup delay follows
		chk(run, 1);
		chk(res_next, 0);
		stat(2'b11);
		$display("test resets done");
		apb(1'b1, A_TICK, 32'h4);
		apb(1'b1, A_IRQ, 32'hC);
		wait_on(1, 5000);
		chk(vec, thru_pkg::VEC_TB);
		pulse(3);
		wait_on(1, 10);
		chk(vec, thru_pkg::VEC_RTC);
		pulse(3);
		wait_on(1, 5000);
		chk(n >= 4080 && n <= 4100, 1);
		$display("test vectors done");
		results();
	end

	// Watchdog on a hung run
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		results();
	end
endmodule : tb_top
